/* hw/fsl_pkg.sv */
// Shared constants and types for the flash sector lock and soft reset block.
// Assumes one core clock of 100 MHz and a serial link clocked by the host.
package fsl_pkg;

  // Instruction codes
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_SECTOR_LOCK = 8'h36;
  localparam logic [7:0] OP_SECTOR_UNLOCK = 8'h39;
  localparam logic [7:0] OP_READ_LOCK = 8'h3D;
  localparam logic [7:0] OP_GLOBAL_LOCK = 8'h7E;
  localparam logic [7:0] OP_GLOBAL_UNLOCK = 8'h98;
  localparam logic [7:0] OP_RESET_ENABLE = 8'h66;
  localparam logic [7:0] OP_RESET_DEVICE = 8'h99;

  // Frame layout
  localparam int ADDR_BITS = 24;
  localparam int CNT_W = 6;
  localparam logic [CNT_W-1:0] CNT_OPCODE = 6'h08;
  localparam logic [CNT_W-1:0] CNT_ADDR = 6'h20;
  localparam logic [CNT_W-1:0] CNT_MAX = 6'h3F;
  localparam logic [2:0] LOCK_BIT_SLOT = 3'h7;

  // Address split into sectors and blocks
  localparam int SECTOR_LSB = 12;
  localparam int BLOCK_LSB = 16;
  localparam int SECTORS_PER_BLOCK = 16;
  localparam int MAX_SECTOR_SPAN = 8;

  // Reset values
  localparam logic LOCK_RESET_VAL = 1'b1;
  localparam logic WEL_RESET_VAL = 1'b0;
  localparam logic [7:0] PARAM_RESET_VAL = 8'h00;

  // Timing
  localparam int CLK_PERIOD_PS = 10000;
  localparam int T_RST_US = 30;
  localparam int RST_CYCLES = (T_RST_US * 1000000) / CLK_PERIOD_PS;
  localparam int RST_CNT_W = 12;
  localparam int T_PUW_MS = 5;

  typedef enum logic [2:0] {
    FSL_READY = 3'b001,
    FSL_ARMED = 3'b010,
    FSL_RESETTING = 3'b100
  } fsl_state_t;

endpackage

/* hw/fsl_frame_if.sv */
// Frame record carried between the link-side shifter and the core logic.
// Link side writes on the serial clock; core side on clk, crossing by toggle and quiet frames.
`timescale 1ns/1ps
interface fsl_frame_if;
  logic [7:0] opcode;
  logic [fsl_pkg::ADDR_BITS-1:0] addr;
  logic [fsl_pkg::CNT_W-1:0] bit_cnt;
  logic query_tgl;
  logic lock_ans;
  logic reject;
  modport link (output opcode, output addr, output bit_cnt, output query_tgl, input lock_ans, input reject);
  modport core (input opcode, input addr, input bit_cnt, input query_tgl, output lock_ans, output reject);
endinterface

/* hw/fsl_sync.sv */
// Two flip-flop synchroniser for levels, any width.
// Assumes d is quasi-static or gray-safe per bit.
`timescale 1ns/1ps
module fsl_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Data
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta <= INIT;
      q <= INIT;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

/* hw/fsl_spi_link.sv */
// Serial link shifter on the host clock: counts bits, captures opcode and address, drives lock byte.
// Assumes the serial clock stops outside frames and cs_b high ends a frame.
`timescale 1ns/1ps
module fsl_spi_link (
  // Link pins
  input wire logic sclk,
  input wire logic cs_b,
  input wire logic serial_in_pin,
  output logic so,
  output logic so_oe_b,
  // Core reset, already synchronised
  input wire logic rst_b,
  // Frame record
  fsl_frame_if.link fr
);
  import fsl_pkg::*;

  logic [ADDR_BITS-2:0] shift;
  logic [1:0] back_s;
  logic frame_rst_b;
  logic in_frame;
  logic [CNT_W-1:0] cnt_now;

  assign frame_rst_b = rst_b & ~cs_b;
  // Last count stays after chip select rises, so the core can judge the frame
  assign cnt_now = in_frame ? fr.bit_cnt : '0;

  // Cleared by chip select high, set by the first clock of a frame
  always_ff @(posedge sclk or negedge frame_rst_b) begin
    if (!frame_rst_b) begin
      in_frame <= 1'b0;
    end else begin
      in_frame <= 1'b1;
    end
  end

  // Bit count restarts with every frame
  always_ff @(posedge sclk or negedge rst_b) begin
    if (!rst_b) begin
      fr.bit_cnt <= '0;
    end else if (cnt_now != CNT_MAX) begin
      fr.bit_cnt <= cnt_now + 6'h01;
    end
  end

  // Rising edge capture of opcode and address
  always_ff @(posedge sclk or negedge rst_b) begin
    if (!rst_b) begin
      shift <= '0;
      fr.opcode <= '0;
      fr.addr <= '0;
      fr.query_tgl <= 1'b0;
    end else begin
      shift <= {shift[ADDR_BITS-3:0], serial_in_pin};
      if (cnt_now == CNT_OPCODE - 6'h01) begin
        fr.opcode <= {shift[6:0], serial_in_pin};
      end
      if (cnt_now == CNT_ADDR - 6'h01) begin
        fr.addr <= {shift, serial_in_pin};
        if (fr.opcode == OP_READ_LOCK) begin
          fr.query_tgl <= ~fr.query_tgl;
        end
      end
    end
  end

  fsl_sync #(.WIDTH(2), .INIT(2'b00)) u_back_sync (
    .clk(sclk),
    .rst_b(rst_b),
    .d({fr.lock_ans, fr.reject}),
    .q(back_s)
  );

  // Lock byte, MSB first on falling edges, seven zeros then the lock bit
  always_ff @(negedge sclk or negedge frame_rst_b) begin
    if (!frame_rst_b) begin
      so <= 1'b0;
      so_oe_b <= 1'b1;
    end else if (fr.opcode == OP_READ_LOCK && cnt_now >= CNT_ADDR && !back_s[0]) begin
      so_oe_b <= 1'b0;
      so <= (cnt_now[2:0] == LOCK_BIT_SLOT) ? back_s[1] : 1'b0;
    end else begin
      so <= 1'b0;
      so_oe_b <= 1'b1;
    end
  end
endmodule

/* hw/fsl_lock_ctrl.sv */
// Volatile block and sector lock array with global lock, unlock, query and two-step soft reset.
// Assumes config and core inputs are on clk; link pins belong to the host serial clock.
`timescale 1ns/1ps
module fsl_lock_ctrl #(
  parameter int NUM_BLOCKS = 32
) (
  // Core clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Serial link
  input wire logic sclk,
  input wire logic cs_b,
  input wire logic serial_in_pin,
  output logic so,
  output logic so_oe_b,
  // Protection configuration
  input wire logic lock_scheme_select,
  input wire logic protect_complement,
  input wire logic sector_granularity,
  input wire logic top_bottom_select,
  input wire logic [2:0] block_protect_field,
  // Write protect query from the array engine
  input wire logic [fsl_pkg::ADDR_BITS-1:0] prot_addr,
  output logic prot_hit,
  // Engine status and volatile settings
  input wire logic core_busy,
  input wire logic suspend_set,
  input wire logic suspend_clear,
  input wire logic param_load,
  input wire logic [7:0] param_value,
  input wire logic bypass_load,
  input wire logic [7:0] bypass_value,
  output logic status_busy,
  output logic write_enable_latch,
  output logic paused_operation_flag,
  output logic [7:0] read_param_bits,
  output logic [7:0] bypass_mode_bits,
  output logic abort_op
);
  import fsl_pkg::*;

  localparam int BLK_W = $clog2(NUM_BLOCKS);
  localparam int NUM_LOCKS = 2 * SECTORS_PER_BLOCK + NUM_BLOCKS - 2;
  localparam int TOTAL_SECTORS = NUM_BLOCKS * SECTORS_PER_BLOCK;
  localparam logic [RST_CNT_W-1:0] RST_LOAD = RST_CNT_W'(RST_CYCLES);

  logic rst_sync_b;
  logic cs_s;
  logic cs_prev;
  logic qt_s;
  logic qt_prev;
  logic frame_end;
  logic cmd_ok;
  logic op_done;
  logic addr_done;
  logic reset_accept;
  logic next_prot;
  logic [NUM_LOCKS-1:0] lock_bits;
  logic [RST_CNT_W-1:0] rst_cnt;
  fsl_state_t state;
  fsl_frame_if fr ();

  // Bottom and top blocks lock per sector, the rest per block
  function automatic int lock_index(input logic [ADDR_BITS-1:0] a);
    logic [BLK_W-1:0] blk;
    blk = a[BLOCK_LSB +: BLK_W];
    if (blk == '0) begin
      lock_index = int'(a[SECTOR_LSB +: 4]);
    end else if (blk == BLK_W'(NUM_BLOCKS - 1)) begin
      lock_index = SECTORS_PER_BLOCK + NUM_BLOCKS - 2 + int'(a[SECTOR_LSB +: 4]);
    end else begin
      lock_index = SECTORS_PER_BLOCK - 1 + int'(blk);
    end
  endfunction

  fsl_sync #(.WIDTH(1), .INIT(1'b0)) u_rst_sync (
    .clk(clk),
    .rst_b(rst_b),
    .d(1'b1),
    .q(rst_sync_b)
  );

  fsl_sync #(.WIDTH(2), .INIT(2'b01)) u_link_sync (
    .clk(clk),
    .rst_b(rst_sync_b),
    .d({fr.query_tgl, cs_b}),
    .q({qt_s, cs_s})
  );

  fsl_spi_link u_link (
    .sclk(sclk),
    .cs_b(cs_b),
    .serial_in_pin(serial_in_pin),
    .so(so),
    .so_oe_b(so_oe_b),
    .rst_b(rst_sync_b),
    .fr(fr)
  );

  // Frame record is quiet once chip select has risen
  assign frame_end = cs_s & ~cs_prev;
  assign cmd_ok = frame_end & (state != FSL_RESETTING);
  assign op_done = (fr.bit_cnt == CNT_OPCODE);
  assign addr_done = (fr.bit_cnt == CNT_ADDR);
  assign reset_accept = cmd_ok & op_done & (state == FSL_ARMED) & (fr.opcode == OP_RESET_DEVICE);

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      cs_prev <= 1'b1;
      qt_prev <= 1'b0;
    end else begin
      cs_prev <= cs_s;
      qt_prev <= qt_s;
    end
  end

  // Reset sequencing
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      state <= FSL_READY;
    end else begin
      unique case (state)
        FSL_READY: begin
          if (cmd_ok && op_done && fr.opcode == OP_RESET_ENABLE) begin
            state <= FSL_ARMED;
          end
        end
        FSL_ARMED: begin
          if (reset_accept) begin
            state <= FSL_RESETTING;
          end else if (cmd_ok && fr.bit_cnt >= CNT_OPCODE &&
                       !(op_done && fr.opcode == OP_RESET_ENABLE)) begin
            state <= FSL_READY;
          end
        end
        FSL_RESETTING: begin
          if (rst_cnt == RST_CNT_W'(1)) begin
            state <= FSL_READY;
          end
        end
        default: begin
          state <= FSL_READY;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      rst_cnt <= '0;
    end else if (reset_accept) begin
      rst_cnt <= RST_LOAD;
    end else if (rst_cnt != '0) begin
      rst_cnt <= rst_cnt - RST_CNT_W'(1);
    end
  end

  // Lock array
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      lock_bits <= {NUM_LOCKS{LOCK_RESET_VAL}};
    end else if (reset_accept) begin
      lock_bits <= {NUM_LOCKS{LOCK_RESET_VAL}};
    end else if (cmd_ok && write_enable_latch) begin
      if (op_done && fr.opcode == OP_GLOBAL_LOCK) begin
        lock_bits <= '1;
      end else if (op_done && fr.opcode == OP_GLOBAL_UNLOCK) begin
        lock_bits <= '0;
      end else if (addr_done && fr.opcode == OP_SECTOR_UNLOCK) begin
        lock_bits[lock_index(fr.addr)] <= 1'b0;
      end else if (addr_done && fr.opcode == OP_SECTOR_LOCK) begin
        lock_bits[lock_index(fr.addr)] <= 1'b1;
      end
    end
  end

  // Lock query answer and reject flag back to the link
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      fr.lock_ans <= LOCK_RESET_VAL;
      fr.reject <= 1'b0;
    end else begin
      fr.reject <= (state == FSL_RESETTING);
      if (qt_s != qt_prev) begin
        fr.lock_ans <= lock_bits[lock_index(fr.addr)];
      end
    end
  end

  // Write enable latch
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      write_enable_latch <= WEL_RESET_VAL;
    end else if (reset_accept) begin
      write_enable_latch <= WEL_RESET_VAL;
    end else if (cmd_ok && op_done && fr.opcode == OP_WRITE_ENABLE) begin
      write_enable_latch <= 1'b1;
    end else if (cmd_ok && op_done && fr.opcode == OP_WRITE_DISABLE) begin
      write_enable_latch <= 1'b0;
    end
  end

  // Volatile settings, set wins over clear
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      paused_operation_flag <= 1'b0;
      read_param_bits <= PARAM_RESET_VAL;
      bypass_mode_bits <= PARAM_RESET_VAL;
    end else if (reset_accept) begin
      paused_operation_flag <= 1'b0;
      read_param_bits <= PARAM_RESET_VAL;
      bypass_mode_bits <= PARAM_RESET_VAL;
    end else begin
      if (suspend_set) begin
        paused_operation_flag <= 1'b1;
      end else if (suspend_clear) begin
        paused_operation_flag <= 1'b0;
      end
      if (param_load) begin
        read_param_bits <= param_value;
      end
      if (bypass_load) begin
        bypass_mode_bits <= bypass_value;
      end
    end
  end

  // Busy and abort
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      status_busy <= 1'b0;
      abort_op <= 1'b0;
    end else begin
      status_busy <= core_busy | (state == FSL_RESETTING);
      abort_op <= reset_accept;
    end
  end

  // Write protection decode
  always_comb begin
    int page;
    int span;
    logic hit;
    // Addresses above the array wrap onto it
    page = int'(prot_addr[BLOCK_LSB+BLK_W-1:SECTOR_LSB]);
    span = 0;
    hit = 1'b0;
    if (lock_scheme_select) begin
      next_prot = lock_bits[lock_index(prot_addr)];
    end else begin
      if (block_protect_field == 3'h7 && !sector_granularity) begin
        span = TOTAL_SECTORS;
      end else if (block_protect_field != 3'h0) begin
        span = 1 << (int'(block_protect_field) - 1);
        if (sector_granularity) begin
          span = (span > MAX_SECTOR_SPAN) ? MAX_SECTOR_SPAN : span;
        end else begin
          span = span * SECTORS_PER_BLOCK;
        end
      end
      if (top_bottom_select) begin
        hit = (page < span);
      end else begin
        hit = (page >= TOTAL_SECTORS - span);
      end
      next_prot = hit ^ protect_complement;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      prot_hit <= 1'b1;
    end else begin
      prot_hit <= next_prot;
    end
  end

  // Checks
  logic [RST_CNT_W-1:0] chk_cnt;

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      chk_cnt <= '0;
    end else if (state == FSL_RESETTING) begin
      chk_cnt <= chk_cnt + RST_CNT_W'(1);
    end else begin
      chk_cnt <= '0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_sync_b);

  wel_gate_a: assert property ((cmd_ok && !write_enable_latch && !reset_accept) |=> $stable(lock_bits))
    else $error("lock bits changed with latch clear");
  glob_lock_a: assert property ((cmd_ok && op_done && write_enable_latch && fr.opcode == OP_GLOBAL_LOCK) |=> &lock_bits)
    else $error("global lock did not set all bits");
  glob_unlock_a: assert property ((cmd_ok && op_done && write_enable_latch && fr.opcode == OP_GLOBAL_UNLOCK)
                                  |=> lock_bits == '0)
    else $error("global unlock did not clear all bits");
  one_unlock_a: assert property ((cmd_ok && addr_done && write_enable_latch && fr.opcode == OP_SECTOR_UNLOCK)
                                 |=> !lock_bits[lock_index($past(fr.addr))])
    else $error("single unlock missed its bit");
  soft_rst_a: assert property (reset_accept |=> (&lock_bits && !write_enable_latch && abort_op
                                                 && !paused_operation_flag && read_param_bits == PARAM_RESET_VAL))
    else $error("soft reset did not restore defaults");
  rst_busy_a: assert property (reset_accept |-> ##2 status_busy [*8])
    else $error("busy not held during reset");
  rst_len_a: assert property ($fell(state == FSL_RESETTING) |-> chk_cnt == RST_LOAD)
    else $error("reset interval length wrong");
  disarm_a: assert property ((state == FSL_ARMED && cmd_ok && fr.bit_cnt >= CNT_OPCODE
                              && fr.opcode != OP_RESET_DEVICE && fr.opcode != OP_RESET_ENABLE) |=> state == FSL_READY)
    else $error("reset enable survived another instruction");
  arm_need_a: assert property ((state != FSL_ARMED && !(state == FSL_RESETTING)) |=> state != FSL_RESETTING)
    else $error("reset without enable");
  scheme_a: assert property ((lock_scheme_select && lock_bits[lock_index(prot_addr)]) |=> prot_hit)
    else $error("locked unit not protected");
  bp_none_a: assert property ((!lock_scheme_select && block_protect_field == 3'h0 && !protect_complement)
                              |=> !prot_hit)
    else $error("protection without block field");
  busy_a: assert property (core_busy |=> status_busy)
    else $error("busy not shown during cycle");
  query_a: assert property ((qt_s != qt_prev) |=> fr.lock_ans == lock_bits[lock_index(fr.addr)])
    else $error("lock answer mismatch");
endmodule

/* sim/fsl_host_model.sv */
// Host serial controller model for the lock block, mode 0, 48 ns bit period.
// Assumes the bench calls its tasks one at a time; the clock stands low outside frames.
`timescale 1ns/1ps
module fsl_host_model #(
  parameter time PUW = 5ms
) (
  // Link pins
  output logic sclk,
  output logic cs_b,
  output logic serial_in_pin,
  input wire logic so,
  input wire logic so_oe_b
);
  import fsl_pkg::*;
  logic [7:0] rd_byte;
  logic rd_driven;
  logic ready;
  initial begin
    sclk = 1'b0;
    cs_b = 1'b1;
    serial_in_pin = 1'b1;
    ready = 1'b0;
    #(PUW) ready = 1'b1;
  end
  // Sends nbits of word MSB first, then clocks nread answer bits in
  task automatic frame(input logic [31:0] word, input int nbits, input int nread);
    int i;
    wait (ready === 1'b1);
    rd_driven = 1'b1;
    rd_byte = 8'h00;
    cs_b = 1'b0;
    #24ns;
    for (i = 0; i < nbits + nread; i++) begin
      if (i < nbits) serial_in_pin = word[nbits-1-i];
      else serial_in_pin = ~serial_in_pin;
      #24ns;
      sclk = 1'b1;
      if (i >= nbits) begin
        rd_byte = {rd_byte[6:0], so};
        if (so_oe_b !== 1'b0) rd_driven = 1'b0;
      end
      #24ns;
      sclk = 1'b0;
    end
    #24ns;
    cs_b = 1'b1;
    serial_in_pin = ~serial_in_pin;
    #100ns;
  endtask
  task automatic cmd(input logic [7:0] op);
    frame({24'h000000, op}, 8, 0);
  endtask
  task automatic addr_cmd(input logic [7:0] op, input logic [23:0] a);
    frame({op, a}, 32, 0);
  endtask
  task automatic query(input logic [23:0] a);
    frame({OP_READ_LOCK, a}, 32, 8);
  endtask
endmodule

/* sim/tb_top.sv */
// Self-checking bench for the lock array and soft reset block.
// Assumes the host model drives the link pins; core inputs move 1 ns after clk rises.
`timescale 1ns/1ps
module tb_top;
  import fsl_pkg::*;
  localparam logic [23:0] A5 = 24'h050000;
  localparam logic [23:0] A6 = 24'h060000;
  logic clk, rst_b, sclk, cs_b, serial_in_pin, so, so_oe_b, prot_hit;
  logic lock_scheme_select, protect_complement, sector_granularity, top_bottom_select;
  logic [2:0] block_protect_field;
  logic [ADDR_BITS-1:0] prot_addr;
  logic core_busy, suspend_set, suspend_clear, param_load, bypass_load;
  logic [7:0] param_value, bypass_value, read_param_bits, bypass_mode_bits;
  logic status_busy, write_enable_latch, paused_operation_flag, abort_op;
  int num_errors = 0;
  int n_tests = 0;
  int n_abort = 0;

  fsl_lock_ctrl #(.NUM_BLOCKS(32)) DUT (.clk, .rst_b, .sclk, .cs_b, .serial_in_pin, .so, .so_oe_b,
    .lock_scheme_select, .protect_complement, .sector_granularity, .top_bottom_select,
    .block_protect_field, .prot_addr, .prot_hit, .core_busy, .suspend_set, .suspend_clear,
    .param_load, .param_value, .bypass_load, .bypass_value, .status_busy, .write_enable_latch,
    .paused_operation_flag, .read_param_bits, .bypass_mode_bits, .abort_op);
  fsl_host_model #(.PUW(2us)) host (.sclk, .cs_b, .serial_in_pin, .so, .so_oe_b);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) if (abort_op === 1'b1) n_abort <= n_abort + 1;

  task automatic finish_test;
    if (num_errors == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic prot(input logic [23:0] a, input logic e);
    tick(1);
    prot_addr = a;
    tick(2);
    check("prot_hit", 8'(prot_hit), 8'(e));
  endtask
  task automatic q(input logic [23:0] a, input logic [7:0] e);
    host.query(a);
    check("lock byte", host.rd_byte, e);
  endtask

  task automatic t_defaults;
    check("wel", 8'(write_enable_latch), 8'h00);
    q(24'h000000, 8'h01);
    check("so driven", 8'(host.rd_driven), 8'h01);
    prot(24'h000000, 1'b1);
    core_busy = 1'b1;
    tick(3);
    check("busy", 8'(status_busy), 8'h01);
    core_busy = 1'b0;
    tick(3);
    check("busy", 8'(status_busy), 8'h00);
  endtask
  task automatic t_single;
    host.addr_cmd(OP_SECTOR_UNLOCK, A5);
    q(A5, 8'h01);
    host.cmd(OP_WRITE_ENABLE);
    check("wel", 8'(write_enable_latch), 8'h01);
    host.addr_cmd(OP_SECTOR_UNLOCK, A5);
    q(A5, 8'h00);
    q(A6, 8'h01);
    prot(A5, 1'b0);
    prot(A6, 1'b1);
    lock_scheme_select = 1'b0;
    prot(A6, 1'b0);
    block_protect_field = 3'h7;
    prot(A5, 1'b1);
    block_protect_field = 3'h1;
    top_bottom_select = 1'b1;
    prot(24'h00F000, 1'b1);
    prot(24'h010000, 1'b0);
    sector_granularity = 1'b1;
    prot(24'h001000, 1'b0);
    protect_complement = 1'b1;
    prot(24'h001000, 1'b1);
    protect_complement = 1'b0;
    sector_granularity = 1'b0;
    top_bottom_select = 1'b0;
    lock_scheme_select = 1'b1;
    block_protect_field = 3'h0;
  endtask
  task automatic t_global;
    host.cmd(OP_WRITE_DISABLE);
    host.cmd(OP_GLOBAL_UNLOCK);
    q(A6, 8'h01);
    host.cmd(OP_WRITE_ENABLE);
    host.cmd(OP_GLOBAL_UNLOCK);
    q(A6, 8'h00);
    q(24'h1FF000, 8'h00);
    host.cmd(OP_WRITE_DISABLE);
    host.cmd(OP_GLOBAL_LOCK);
    q(A6, 8'h00);
    host.cmd(OP_WRITE_ENABLE);
    host.cmd(OP_GLOBAL_LOCK);
    q(A6, 8'h01);
    q(A5, 8'h01);
    host.cmd(OP_GLOBAL_UNLOCK);
  endtask
  task automatic t_reset;
    tick(1);
    param_load = 1'b1;
    param_value = 8'hA5;
    bypass_load = 1'b1;
    bypass_value = 8'h3C;
    suspend_set = 1'b1;
    suspend_clear = 1'b1;
    tick(1);
    param_load = 1'b0;
    bypass_load = 1'b0;
    suspend_set = 1'b0;
    suspend_clear = 1'b0;
    tick(2);
    check("params", read_param_bits, 8'hA5);
    check("bypass", bypass_mode_bits, 8'h3C);
    check("pause", 8'(paused_operation_flag), 8'h01);
    check("busy", 8'(status_busy), 8'h00);
    host.cmd(OP_RESET_DEVICE);
    check("aborts", 8'(n_abort), 8'h00);
    host.cmd(OP_RESET_ENABLE);
    host.cmd(OP_WRITE_ENABLE);
    host.cmd(OP_RESET_DEVICE);
    check("aborts", 8'(n_abort), 8'h00);
    host.cmd(OP_RESET_ENABLE);
    host.cmd(OP_RESET_DEVICE);
    check("aborts", 8'(n_abort), 8'h01);
    check("busy", 8'(status_busy), 8'h01);
    check("wel", 8'(write_enable_latch), 8'h00);
    check("pause", 8'(paused_operation_flag), 8'h00);
    check("params", read_param_bits, 8'h00);
    check("bypass", bypass_mode_bits, 8'h00);
    host.query(A6);
    check("so driven", 8'(host.rd_driven), 8'h00);
    host.cmd(OP_WRITE_ENABLE);
    check("wel", 8'(write_enable_latch), 8'h00);
    tick(2400);
    check("busy", 8'(status_busy), 8'h01);
    tick(500);
    check("busy", 8'(status_busy), 8'h00);
    q(A6, 8'h01);
    host.cmd(OP_WRITE_ENABLE);
    check("wel", 8'(write_enable_latch), 8'h01);
  endtask

  initial begin
    rst_b = 1'b0;
    lock_scheme_select = 1'b1;
    protect_complement = 1'b0;
    sector_granularity = 1'b0;
    top_bottom_select = 1'b0;
    block_protect_field = 3'h0;
    prot_addr = 24'h000000;
    core_busy = 1'b0;
    suspend_set = 1'b0;
    suspend_clear = 1'b0;
    param_load = 1'b0;
    param_value = 8'h00;
    bypass_load = 1'b0;
    bypass_value = 8'h00;
    tick(2);
    rst_b = 1'b1;
    tick(10);
    t_defaults();
    t_single();
    t_global();
    t_reset();
    finish_test();
  end
  initial begin
    #500us;
    num_errors++;
    finish_test();
  end
endmodule
